// File: pkg/mram_spi_map.svh
`ifndef MRAM_SPI_MAP_SVH
`define MRAM_SPI_MAP_SVH

// ----------------------------------------------------------------
// status register layout and reset value
// ----------------------------------------------------------------
`define ST_LOCK_BIT      7
`define ST_BP_HI_BIT     3
`define ST_BP_LO_BIT     2
`define ST_WLATCH_BIT    1
`define ST_RESET         8'h00

// ----------------------------------------------------------------
// geometry and timing
// ----------------------------------------------------------------
`define MEM_ADDR_W       17
`define ADDR_BYTES       2'h3
`define FIFO_DEPTH       8
`define CLK_MHZ          50
`define SLEEP_ENTRY_NS   3000
`define WAKE_DELAY_NS    400
// least times, rounded up to whole clock cycles
`define SLEEP_ENTRY_CYC  ((`SLEEP_ENTRY_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_DELAY_CYC   ((`WAKE_DELAY_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: pkg/mram_spi_pkg.sv
package mram_spi_pkg;

  // command opcodes
  typedef enum logic [7:0] {
    OP_STATUS_WRITE = 8'h01,
    OP_WRITE        = 8'h02,
    OP_READ         = 8'h03,
    OP_CLR_LATCH    = 8'h04,
    OP_STATUS_READ  = 8'h05,
    OP_SET_LATCH    = 8'h06,
    OP_WAKE         = 8'hab,
    OP_SLEEP        = 8'hb9
  } opcode_t;

  // command frame states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_OPCODE = 8'h02,
    ST_ADDR   = 8'h04,
    ST_RDATA  = 8'h08,
    ST_WDATA  = 8'h10,
    ST_SRD    = 8'h20,
    ST_SWR    = 8'h40,
    ST_IGNORE = 8'h80
  } frame_state_t;

endpackage : mram_spi_pkg

// File: core/pin_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for pins that arrive from outside clk
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage; reset to idle levels so no false edge follows
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (ce) begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync

// File: core/word_fifo.sv
`timescale 1ns/1ps

// flop-based fifo with valid/ready on both sides
module word_fifo #(
  parameter int W     = 25,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   count_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // full and empty follow the occupancy count exactly
  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= bump(wr_ptr_q);
      if (pop)  rd_ptr_q <= bump(rd_ptr_q);
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end

endmodule : word_fifo

// File: core/serial_mram_spi_command_slave.sv
`timescale 1ns/1ps
`include "mram_spi_map.svh"

// Summary of operation
// - at select falling, clock level low picks mode 0, high picks mode 3
// - input sampled on rising clock, output changes on falling clock
// - first byte is opcode; one command per select low period
// - opcode 06h sets the write latch, status bit 1
// - opcode 04h clears the write latch when the command completes
// - write latch is clear after power-up reset
// - status or memory writes need the latch set beforehand
// - opcode 05h returns the status byte, allowed at any time except while asleep or during the wake delay
// - bit 7 lock flag, bits 3:2 block protect, bit 1 write latch
// - all status bits reset to zero
// - status writable if latch set and lock clear or protect pin high
// - protect bits 00 none, 01 upper quarter, 10 upper half, 11 all
// - protect pin high: protect bits alone rule and may be rewritten
// - protect pin low with lock set: protect bits frozen
// - opcode 01h with one data byte replaces the status register except the write latch bit 1
// - opcode 03h, 24-bit address, bits 16:0 used, sequential read out
// - read address wraps from top of memory to zero
// - opcode 02h, 24-bit address, sequential writes wrapping to zero
// - writes complete at full rate, no busy period
// - opcode b9h enters sleep, low standby after entry delay
// - opcode abh wakes after the wake delay
// - serial output driven only while returning data, else released
// - hold low pauses operation, clock and select edges ignored
module serial_mram_spi_command_slave #(
  parameter int ADDR_W     = `MEM_ADDR_W,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              cs_n_pin,
  input  wire logic              sck_pin,
  input  wire logic              si_pin,
  input  wire logic              wp_n_pin,
  input  wire logic              hold_n_pin,
  output logic                   so_out,
  output logic                   so_oe,
  output logic                   mem_wr_valid,
  input  wire logic              mem_wr_ready,
  output logic      [ADDR_W-1:0] mem_wr_addr,
  output logic      [7:0]        mem_wr_data,
  output logic                   mem_rd_req,
  output logic      [ADDR_W-1:0] mem_rd_addr,
  input  wire logic              mem_rd_valid,
  input  wire logic [7:0]        mem_rd_data,
  output logic      [7:0]        status_out,
  output logic                   spi_mode3,
  output logic                   regulators_off,
  output logic                   standby_low,
  output logic                   wr_dropped
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam int            WW        = ADDR_W + 8;
  localparam int            SLEEP_CYC = (`SLEEP_ENTRY_CYC < 1) ? 1 : `SLEEP_ENTRY_CYC;
  localparam int            WAKE_CYC  = (`WAKE_DELAY_CYC < 1) ? 1 : `WAKE_DELAY_CYC;
  localparam logic [15:0]   SLEEP_LD  = 16'(SLEEP_CYC);
  localparam logic [15:0]   WAKE_LD   = 16'(WAKE_CYC);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  logic       cs_n_s;
  logic       sck_s;
  logic       si_s;
  logic       wp_n_s;
  logic       hold_n_s;
  logic       sck_prev_q;
  logic       cs_prev_q;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_fall;
  logic       cs_rise;

  pin_sync #(
    .W       (5),
    .RST_VAL (5'h13) // idle: select high, clock low, data low, wp and hold high
  ) u_pin_sync (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .pin_in   ({cs_n_pin, sck_pin, si_pin, wp_n_pin, hold_n_pin}),
    .sync_out (pins_s)
  );

  assign {cs_n_s, sck_s, si_s, wp_n_s, hold_n_s} = pins_s;

  // previous levels track even during hold, so release makes no phantom edge
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else if (ce) begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
    end
  end

  // edges only count while hold is released
  assign cs_fall  = ce & hold_n_s & cs_prev_q & ~cs_n_s;
  assign cs_rise  = ce & hold_n_s & ~cs_prev_q & cs_n_s;
  assign sck_rise = ce & hold_n_s & ~cs_n_s & ~cs_prev_q & ~sck_prev_q & sck_s;
  assign sck_fall = ce & hold_n_s & ~cs_n_s & ~cs_prev_q & sck_prev_q & ~sck_s;

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  logic [7:0] status_q;
  logic       wlatch;
  logic       status_writable;

  // region selected by the two protect bits
  function automatic logic addr_protected(input logic [ADDR_W-1:0] a,
                                          input logic [1:0]        bp);
    case (bp)
      2'h0:    addr_protected = 1'b0;
      2'h1:    addr_protected = &a[ADDR_W-1 -: 2];
      2'h2:    addr_protected = a[ADDR_W-1];
      default: addr_protected = 1'b1;
    endcase
  endfunction : addr_protected

  assign wlatch = status_q[`ST_WLATCH_BIT];
  // lock flag with protect pin low blocks status writes; the latch commands still change bit 1
  assign status_writable = wlatch & (~status_q[`ST_LOCK_BIT] | wp_n_s);

  // ----------------------------------------------------------------
  // command frame
  // ----------------------------------------------------------------
  mram_spi_pkg::frame_state_t state_q;
  mram_spi_pkg::opcode_t      pend_op_q;
  logic                       pend_v_q;
  logic                       is_read_q;
  logic [2:0]                 bit_cnt_q;
  logic [6:0]                 shift_q;
  logic [1:0]                 addr_cnt_q;
  logic [ADDR_W-1:0]          addr_q;
  logic                       asleep_q;
  logic                       waking_q;
  logic [7:0]                 rx_byte;
  logic                       byte_done;
  logic                       addr_done;
  logic                       status_wr_ev;
  logic                       wr_byte_ev;
  logic                       rd_load_ev;

  assign rx_byte   = {shift_q, si_s};
  assign byte_done = sck_rise & (bit_cnt_q == 3'h7);
  assign addr_done = byte_done & (state_q == mram_spi_pkg::ST_ADDR) &
                     (addr_cnt_q == `ADDR_BYTES - 2'h1);

  // bit counter and input shifter run on every rising clock of the frame
  always_ff @(posedge clk) begin
    if (rst) begin
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= rx_byte[6:0];
    end
  end

  // clock level at select falling picks the mode
  always_ff @(posedge clk) begin
    if (rst) begin
      spi_mode3 <= 1'b0;
    end else if (cs_fall) begin
      spi_mode3 <= sck_s;
    end
  end

  // frame sequencer: opcode, address, data phases
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= mram_spi_pkg::ST_IDLE;
      pend_op_q  <= mram_spi_pkg::OP_SET_LATCH;
      pend_v_q   <= 1'b0;
      is_read_q  <= 1'b0;
      addr_cnt_q <= 2'h0;
    end else if (cs_rise) begin
      state_q  <= mram_spi_pkg::ST_IDLE;
      pend_v_q <= 1'b0;
    end else if (cs_fall) begin
      // a wake delay in progress keeps the device deaf
      state_q    <= waking_q ? mram_spi_pkg::ST_IGNORE : mram_spi_pkg::ST_OPCODE;
      addr_cnt_q <= 2'h0;
    end else if (byte_done) begin
      case (state_q)
        mram_spi_pkg::ST_OPCODE: begin
          state_q <= mram_spi_pkg::ST_IGNORE;
          if (asleep_q) begin
            // only the wake opcode is heard while asleep
            if (rx_byte == mram_spi_pkg::OP_WAKE) begin
              pend_op_q <= mram_spi_pkg::OP_WAKE;
              pend_v_q  <= 1'b1;
            end
          end else begin
            case (rx_byte)
              mram_spi_pkg::OP_SET_LATCH, mram_spi_pkg::OP_CLR_LATCH,
              mram_spi_pkg::OP_SLEEP: begin
                pend_op_q <= mram_spi_pkg::opcode_t'(rx_byte);
                pend_v_q  <= 1'b1;
              end
              mram_spi_pkg::OP_STATUS_READ:  state_q <= mram_spi_pkg::ST_SRD;
              mram_spi_pkg::OP_STATUS_WRITE: state_q <= mram_spi_pkg::ST_SWR;
              mram_spi_pkg::OP_READ: begin
                state_q   <= mram_spi_pkg::ST_ADDR;
                is_read_q <= 1'b1;
              end
              mram_spi_pkg::OP_WRITE: begin
                state_q   <= mram_spi_pkg::ST_ADDR;
                is_read_q <= 1'b0;
              end
              default: state_q <= mram_spi_pkg::ST_IGNORE;
            endcase
          end
        end
        mram_spi_pkg::ST_ADDR: begin
          addr_cnt_q <= addr_cnt_q + 2'h1;
          if (addr_done) begin
            state_q <= is_read_q ? mram_spi_pkg::ST_RDATA : mram_spi_pkg::ST_WDATA;
          end
        end
        mram_spi_pkg::ST_SWR: state_q <= mram_spi_pkg::ST_IGNORE;
        mram_spi_pkg::ST_IDLE, mram_spi_pkg::ST_RDATA, mram_spi_pkg::ST_WDATA,
        mram_spi_pkg::ST_SRD, mram_spi_pkg::ST_IGNORE: state_q <= state_q;
        default: state_q <= mram_spi_pkg::ST_IGNORE;
      endcase
    end
  end

  // address register: three bytes shift in, upper bits fall off the top
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= '0;
    end else if (byte_done && state_q == mram_spi_pkg::ST_ADDR) begin
      addr_q <= {addr_q[ADDR_W-9:0], rx_byte};
    end else if (wr_byte_ev || rd_load_ev) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  assign status_wr_ev = byte_done & (state_q == mram_spi_pkg::ST_SWR) & status_writable;

  // latch commands act only on a clean byte boundary at select rising
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= `ST_RESET;
    end else if (cs_rise && pend_v_q && bit_cnt_q == 3'h0) begin
      if (pend_op_q == mram_spi_pkg::OP_SET_LATCH)
        status_q[`ST_WLATCH_BIT] <= 1'b1;
      else if (pend_op_q == mram_spi_pkg::OP_CLR_LATCH)
        status_q[`ST_WLATCH_BIT] <= 1'b0;
    end else if (status_wr_ev) begin
      // the latch bit itself is not taken from the data byte
      status_q <= {rx_byte[7:2], wlatch, rx_byte[0]};
    end
  end

  assign status_out = status_q;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rd_buf_q;
  logic [7:0] out_sh_q;
  logic       out_live_q;
  logic       out_phase;

  assign out_phase  = (state_q == mram_spi_pkg::ST_SRD) | (state_q == mram_spi_pkg::ST_RDATA);
  assign rd_load_ev = sck_fall & (bit_cnt_q == 3'h0) & (state_q == mram_spi_pkg::ST_RDATA);

  // fetch at address end and after each byte is loaded; memory must answer
  // within half a serial clock, which bounds the usable link rate
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rd_req  <= 1'b0;
      mem_rd_addr <= '0;
    end else if (ce) begin
      mem_rd_req <= 1'b0;
      if (addr_done && is_read_q) begin
        mem_rd_req  <= 1'b1;
        mem_rd_addr <= {addr_q[ADDR_W-9:0], rx_byte};
      end else if (rd_load_ev) begin
        mem_rd_req  <= 1'b1;
        mem_rd_addr <= addr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_buf_q <= 8'h00;
    end else if (ce && mem_rd_valid) begin
      rd_buf_q <= mem_rd_data;
    end
  end

  // output shifter: loads on the falling edge at a byte boundary
  always_ff @(posedge clk) begin
    if (rst) begin
      out_sh_q   <= 8'h00;
      out_live_q <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      out_live_q <= 1'b0;
    end else if (sck_fall && out_phase) begin
      if (bit_cnt_q == 3'h0) begin
        // status read repeats the live status byte
        out_sh_q   <= (state_q == mram_spi_pkg::ST_SRD) ? status_q : rd_buf_q;
        out_live_q <= 1'b1;
      end else begin
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

  assign so_out = out_sh_q[7];
  assign so_oe  = out_live_q & out_phase & hold_n_s & ~cs_n_s;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  logic          wr_allowed;
  logic          stage_v_q;
  logic [WW-1:0] stage_q;
  logic          stage_ready;

  assign wr_allowed = wlatch & ~addr_protected(addr_q, status_q[`ST_BP_HI_BIT:`ST_BP_LO_BIT]);
  assign wr_byte_ev = byte_done & (state_q == mram_spi_pkg::ST_WDATA);

  // refused bytes advance the address but never reach the fifo;
  // the serial side cannot stall, so a byte that finds the stage busy is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_v_q  <= 1'b0;
      stage_q    <= '0;
      wr_dropped <= 1'b0;
    end else if (ce) begin
      wr_dropped <= 1'b0;
      if (stage_v_q && stage_ready) stage_v_q <= 1'b0;
      if (wr_byte_ev && wr_allowed) begin
        if (!stage_v_q || stage_ready) begin
          stage_v_q <= 1'b1;
          stage_q   <= {addr_q, rx_byte};
        end else begin
          wr_dropped <= 1'b1;
        end
      end
    end
  end

  word_fifo #(
    .W     (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (stage_v_q),
    .in_ready  (stage_ready),
    .in_data   (stage_q),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  ({mem_wr_addr, mem_wr_data})
  );

  // ----------------------------------------------------------------
  // sleep and wake
  // ----------------------------------------------------------------
  logic [15:0] pwr_cnt_q;

  // regulators drop at once; low standby and wake need the delay to run out
  always_ff @(posedge clk) begin
    if (rst) begin
      asleep_q    <= 1'b0;
      waking_q    <= 1'b0;
      standby_low <= 1'b0;
      pwr_cnt_q   <= 16'h0000;
    end else if (ce) begin
      if (cs_rise && pend_v_q && bit_cnt_q == 3'h0 &&
          pend_op_q == mram_spi_pkg::OP_SLEEP) begin
        asleep_q  <= 1'b1;
        pwr_cnt_q <= SLEEP_LD;
      end else if (cs_rise && pend_v_q && bit_cnt_q == 3'h0 &&
                   pend_op_q == mram_spi_pkg::OP_WAKE) begin
        waking_q    <= 1'b1;
        standby_low <= 1'b0;
        pwr_cnt_q   <= WAKE_LD;
      end else if (pwr_cnt_q != 16'h0000) begin
        pwr_cnt_q <= pwr_cnt_q - 16'h0001;
        if (pwr_cnt_q == 16'h0001) begin
          if (waking_q) begin
            waking_q <= 1'b0;
            asleep_q <= 1'b0;
          end else if (asleep_q) begin
            standby_low <= 1'b1;
          end
        end
      end
    end
  end

  assign regulators_off = asleep_q & ~waking_q;

endmodule : serial_mram_spi_command_slave

// File: tb/serial_mram_spi_command_slave_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// pin and memory side checks
// ----------------------------------------------------------------
module mram_spi_checker #(
  parameter int ADDR_W = 17
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              cs_n_pin,
  input wire logic              wp_n_pin,
  input wire logic              hold_n_pin,
  input wire logic              so_oe,
  input wire logic              mem_wr_valid,
  input wire logic              mem_wr_ready,
  input wire logic [ADDR_W-1:0] mem_wr_addr,
  input wire logic [7:0]        mem_wr_data,
  input wire logic              mem_rd_req,
  input wire logic [7:0]        status_out,
  input wire logic              regulators_off,
  input wire logic              standby_low,
  input wire logic              wr_dropped
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // four clocks covers the two-flop pin sync
  property p_rst; @(posedge clk) disable iff (1'b0) rst |=> status_out == 8'h00 && !so_oe;
  endproperty
  property p_cs_rel; cs_n_pin [*4] |-> !so_oe; endproperty
  property p_hold; !hold_n_pin [*4] |-> !so_oe; endproperty
  property p_wr_hold;
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable({mem_wr_addr, mem_wr_data});
  endproperty
  property p_rd_pulse; mem_rd_req |=> !mem_rd_req; endproperty
  property p_drop_pulse; wr_dropped |=> !wr_dropped; endproperty
  property p_bp_frozen; !wp_n_pin [*4] ##0 status_out[7] |=> $stable(status_out[3:2]);
  endproperty
  property p_standby; $rose(standby_low) |-> regulators_off; endproperty
  a_rst: assert property (p_rst) else $error("reset left state set");
  a_cs_rel: assert property (p_cs_rel) else $error("output driven while idle");
  a_hold: assert property (p_hold) else $error("output driven in hold");
  a_wr_hold: assert property (p_wr_hold) else $error("write changed while stalled");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request too long");
  a_drop_pulse: assert property (p_drop_pulse) else $error("drop flag too long");
  a_bp_frozen: assert property (p_bp_frozen) else $error("protect bits moved");
  a_standby: assert property (p_standby) else $error("standby while awake");
  c_wr: cover property (mem_wr_valid && mem_wr_ready);
  c_drop: cover property (wr_dropped);
  c_sleep: cover property ($rose(standby_low));
endmodule : mram_spi_checker

bind serial_mram_spi_command_slave mram_spi_checker #(.ADDR_W(ADDR_W)) u_chk (.clk, .rst,
  .cs_n_pin, .wp_n_pin, .hold_n_pin, .so_oe, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr,
  .mem_wr_data, .mem_rd_req, .status_out, .regulators_off, .standby_low, .wr_dropped);

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
// host controller, 8 system clocks per half period so the pin sync keeps up
module spi_host_model (
  input wire logic clk,
  input wire logic so,
  output logic     cs_n,
  output logic     sck,
  output logic     si
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk
  // one frame; idle clock level at select fall picks the mode
  task automatic frame(input logic m3, input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    sck = m3;
    wait_clk(4);
    cs_n = 1'b0; // one command per select low period
    wait_clk(4); // clock moves only once select is seen low
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        sck = 1'b0; // data set up while clock low, taken on rise
        si  = tx[i][k];
        wait_clk(8);
        b[k] = so;
        sck = 1'b1;
        wait_clk(8);
      end
      rx.push_back(b);
    end
    sck = m3;
    wait_clk(4);
    cs_n = 1'b1; // only after whole bytes
    si = ~si;    // released line shows no stale value
    wait_clk(10);
  endtask : frame
endmodule : spi_host_model

// File: tb/serial_mram_spi_command_slave_tb_top.sv
`timescale 1ns/1ps
module serial_mram_spi_command_slave_tb_top;
  logic clk, rst, ce, wp_n, hold_n, wr_rdy, m3;
  logic rd_vld;
  logic [7:0] rd_data;
  logic cs_n, sck, si, so_out, so_oe, wr_vld, rd_req, mode3, reg_off, stby, dropped;
  logic [16:0] wr_addr, rd_addr;
  logic [7:0] wr_data, status, mem [0:131071], rx[$], tx[$];
  int fails = 0, checks = 0, drops = 0;
  always #10 clk = ~clk;
  // memory behind the block: one clock read latency, write side can stall
  always @(posedge clk) begin
    rd_vld <= #1 rd_req;
    rd_data <= #1 mem[rd_addr];
    if (wr_vld && wr_rdy) mem[wr_addr] <= wr_data;
    if (dropped === 1'b1) drops++;
  end
  serial_mram_spi_command_slave u_serial_mram_spi_command_slave (.clk(clk), .rst(rst),
    .ce(ce), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si), .wp_n_pin(wp_n),
    .hold_n_pin(hold_n), .so_out(so_out), .so_oe(so_oe), .mem_wr_valid(wr_vld),
    .mem_wr_ready(wr_rdy), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data), .mem_rd_req(rd_req),
    .mem_rd_addr(rd_addr), .mem_rd_valid(rd_vld), .mem_rd_data(rd_data), .status_out(status),
    .spi_mode3(mode3), .regulators_off(reg_off), .standby_low(stby), .wr_dropped(dropped));
  spi_host_model u_spi_host_model (.clk(clk), .so(so_oe ? so_out : ~so_out), .cs_n(cs_n),
    .sck(sck), .si(si));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic x(input logic [7:0] t[$]);
    u_spi_host_model.frame(m3, t, rx);
  endtask : x
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_modes;
    x({8'h05, 8'h00});
    check(rx[1], 8'h00);
    check({7'h0, mode3}, 8'h00);
    m3 = 1'b1;
    x({8'h05, 8'h00});
    check(rx[1], 8'h00);
    check({7'h0, mode3}, 8'h01);
    m3 = 1'b0;
    x({8'h02, 8'h00, 8'h00, 8'h10, 8'h5a});
    check(mem[17'h10], 8'h00);
    x({8'h06});
    check(status, 8'h02);
    x({8'h04});
    check(status, 8'h00);
    // clock enable low: the whole frame must go unseen
    ce = 1'b0;
    x({8'h06});
    ce = 1'b1;
    check(status, 8'h00);
    $display("t_modes done");
  endtask : t_modes
  task automatic t_wrap;
    x({8'h06});
    x({8'h02, 8'hff, 8'hff, 8'hff, 8'ha5, 8'h3c});
    check(mem[17'h1ffff], 8'ha5);
    check(mem[17'h0], 8'h3c);
    x({8'h03, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00});
    check(rx[4], 8'ha5);
    check(rx[5], 8'h3c);
    $display("t_wrap done");
  endtask : t_wrap
  task automatic t_protect;
    x({8'h01, 8'h0c});
    check(status, 8'h0e);
    x({8'h02, 8'h00, 8'h00, 8'h20, 8'h77});
    check(mem[17'h20], 8'h00);
    x({8'h01, 8'h84});
    wp_n = 1'b0;
    x({8'h01, 8'h00});
    check(status, 8'h86);
    wp_n = 1'b1;
    x({8'h01, 8'h00});
    check(status, 8'h02);
    $display("t_protect done");
  endtask : t_protect
  task automatic t_overflow;
    // stalled memory: eight in the queue, one staged, the tenth lost
    wr_rdy = 1'b0;
    tx = {8'h02, 8'h00, 8'h01, 8'h00};
    for (int i = 1; i <= 10; i++) tx.push_back(8'(i));
    x(tx);
    wr_rdy = 1'b1;
    u_spi_host_model.wait_clk(30);
    check(8'(drops), 8'h01);
    check(mem[17'h108], 8'h09);
    check(mem[17'h109], 8'h00);
    $display("t_overflow done");
  endtask : t_overflow
  task automatic t_sleep_hold;
    x({8'hb9});
    u_spi_host_model.wait_clk(160);
    check({7'h0, stby}, 8'h01);
    x({8'hab});
    u_spi_host_model.wait_clk(30);
    check({7'h0, reg_off}, 8'h00);
    fork
      x({8'h05, 8'h00});
      begin
        // hold low just after the first data rise, released before the next fall
        u_spi_host_model.wait_clk(145);
        check({7'h0, so_oe}, 8'h01);
        hold_n = 1'b0;
        u_spi_host_model.wait_clk(4);
        check({7'h0, so_oe}, 8'h00);
        hold_n = 1'b1;
      end
    join
    check(rx[1], 8'h02);
    $display("t_sleep_hold done");
  endtask : t_sleep_hold
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    wp_n = 1'b1;
    hold_n = 1'b1;
    wr_rdy = 1'b1;
    m3 = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    u_spi_host_model.wait_clk(5);
    rst = 1'b0;
    u_spi_host_model.wait_clk(5);
    t_modes();
    t_wrap();
    t_protect();
    t_overflow();
    t_sleep_hold();
    final_report();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule : serial_mram_spi_command_slave_tb_top
